// file: hdl/ard_cmd_exec.sv
// task-file command engine for sector read, verify, recalibrate, sense and seek
// assumes an apb master for the task file and a media engine that fills the buffer
//
// Summary of operation
// - sector count of zero means 256 sectors; otherwise 1 to 255
// - codes 20h and 21h both run the pio sector read
// - transfer starts at the task-file address and walks consecutive sectors
// - lba: cyl high 23-16, cyl low 15-8, sector 7-0, head 27-24
// - per sector: busy, fill buffer, data request, busy off, interrupt
// - on read error stop at failing sector, its address stays in registers
// - flawed sector data stays in the buffer for the host
// - codes 40h and 41h verify without data request or data to host
// - verify holds busy, then clears it with one interrupt at the end
// - failed verify leaves failing address and count of sectors not verified
// - any 1xh code completes as a no-op
// - code 03h puts the previous extended error code in the error register
// - codes 00h, 21h, 2fh, 11h, 18h for none, address and ecc conditions
// - codes 1fh transfer error or abort, 03h write or erase failure
// - codes 35h, 36h voltage out of tolerance, 09h miscellaneous
// - self test, diagnostic, id not found and spare exhaustion codes
// - any 7xh code only range-checks the address and posts an error when it is out of range
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
module ard_cmd_exec
  import ard_pkg::*;
#(
  parameter int unsigned CYLS     = 1024,
  parameter int unsigned HEADS    = 16,
  parameter int unsigned SPT      = 63,
  parameter logic        DRIVE_ID = 1'b0
) (
  input  wire logic              pclk,         // clock, 100 MHz
  input  wire logic              presetn,      // async reset, active low
  input  wire logic              psel,         // apb select
  input  wire logic              penable,      // apb access phase
  input  wire logic              pwrite,       // apb write
  input  wire logic [ADDR_W-1:0] paddr,        // apb byte address
  input  wire logic [31:0]       pwdata,       // apb write data
  output logic      [31:0]       prdata,       // apb read data
  output logic                   pready,       // apb ready
  output logic                   pslverr,      // apb error
  output logic                   intrq,        // host interrupt line, active high
  output ard_media_req_t         media_req,    // sector fetch request fields
  output logic                   media_go,     // fetch request, held until done
  input  wire ard_media_rsp_t    media_rsp,    // fetch completion with code
  input  wire logic              media_wr,     // buffer write strobe
  input  wire logic [7:0]        media_waddr,  // buffer word address
  input  wire logic [15:0]       media_wdata   // buffer word
);
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_CHECK = 3'b001,
    S_WAIT  = 3'b011,
    S_XFER  = 3'b010,
    S_NEXT  = 3'b110
  } ard_state_t;

  ard_state_t  state_reg;
  logic [7:0]  count_reg;
  logic [7:0]  sect_reg;
  logic [7:0]  cyl_lo_reg;
  logic [7:0]  cyl_hi_reg;
  logic [7:0]  drvhd_reg;
  logic [7:0]  feat_reg;
  logic [7:0]  error_reg;
  logic [7:0]  ext_reg;
  logic        err_flag_reg;
  logic        verify_reg;
  logic        last_reg;
  logic [8:0]  remain_reg;
  logic [7:0]  ptr_reg;
  logic        intrq_reg;
  logic [15:0] buf_rdata;
  logic [27:0] lba;
  logic [7:0]  chk_ext;

  generate
    if (SECTOR_WORDS != 256 || MAX_SECTORS != 256) begin : g_chk
      $error("ard_cmd_exec counters are sized for 256-word sectors");
    end
  endgenerate

  // apb decode
  logic        acc;
  logic        hit;
  logic [2:0]  idx;
  logic        wr_acc;
  logic        rd_acc;
  logic        busy;
  logic        drq;
  logic        cmd_wr;
  logic [7:0]  cmd;
  logic        drv_match;
  logic        data_rd;
  logic [7:0]  status;

  assign acc       = psel & penable;
  assign hit       = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:5] == '0);
  assign idx       = paddr[4:2];
  assign wr_acc    = acc & hit & pwrite;
  assign rd_acc    = acc & hit & ~pwrite;
  assign busy      = (state_reg == S_CHECK) || (state_reg == S_WAIT) || (state_reg == S_NEXT);
  assign drq       = (state_reg == S_XFER);
  assign cmd       = pwdata[7:0];
  assign drv_match = (drvhd_reg[DH_DRV] == DRIVE_ID);
  // a new command during the data phase abandons the remaining sectors
  assign cmd_wr    = wr_acc && (idx == 3'(IDX_CMD)) && !busy && drv_match;
  assign data_rd   = rd_acc && (idx == 3'(IDX_DATA)) && drq;
  assign pready    = 1'b1;
  assign pslverr   = acc & ~hit;
  assign intrq     = intrq_reg;

  always_comb begin
    status         = 8'h00;
    status[ST_BSY] = busy;
    status[ST_RDY] = ~busy;
    status[ST_DSC] = ~busy;
    status[ST_DRQ] = drq;
    status[ST_ERR] = err_flag_reg;
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_acc) begin
      case (idx)
        3'(IDX_DATA):   prdata = {16'h0000, buf_rdata};
        3'(IDX_FEAT):   prdata = {24'h0, error_reg};
        3'(IDX_COUNT):  prdata = {24'h0, count_reg};
        3'(IDX_SECT):   prdata = {24'h0, sect_reg};
        3'(IDX_CYL_LO): prdata = {24'h0, cyl_lo_reg};
        3'(IDX_CYL_HI): prdata = {24'h0, cyl_hi_reg};
        3'(IDX_DRVHD):  prdata = {24'h0, drvhd_reg};
        3'(IDX_CMD):    prdata = {24'h0, status};
        default:        prdata = 32'h0000_0000;
      endcase
    end
  end

  ard_addr #(
    .CYLS  (CYLS),
    .HEADS (HEADS),
    .SPT   (SPT)
  ) u_addr (
    .lba_mode (drvhd_reg[DH_LBA]),
    .head     (drvhd_reg[3:0]),
    .cyl      ({cyl_hi_reg, cyl_lo_reg}),
    .sect     (sect_reg),
    .lba      (lba),
    .ext      (chk_ext)
  );

  ard_sbuf #(
    .WORDS (SECTOR_WORDS),
    .DW    (16)
  ) u_sbuf (
    .pclk    (pclk),
    .wr_en   (media_wr),
    .wr_addr (media_waddr),
    .wr_data (media_wdata),
    .rd_addr (ptr_reg),
    .rd_data (buf_rdata)
  );

  // sequence events, decoded once for the processes below
  logic       fetch_done;
  logic       fetch_ok;
  logic       chk_fail;
  logic       sector_drained;
  logic       cmd_rw;
  logic       cmd_immediate;
  logic [7:0] imm_ext;

  assign fetch_done     = (state_reg == S_WAIT) && media_rsp.done;
  assign fetch_ok       = ard_ext_ok(media_rsp.status);
  assign chk_fail       = (state_reg == S_CHECK) && (chk_ext != EXT_NONE);
  assign sector_drained = data_rd && (ptr_reg == 8'hff);
  assign cmd_rw         = (cmd == CMD_READ_A) || (cmd == CMD_READ_B) ||
                          (cmd == CMD_VERIFY_A) || (cmd == CMD_VERIFY_B);
  assign cmd_immediate  = cmd_wr && !cmd_rw;

  always_comb begin
    if (cmd[7:4] == CMD_RECAL_HI) begin
      imm_ext = EXT_NONE;
    end else if (cmd[7:4] == CMD_SEEK_HI) begin
      imm_ext = chk_ext;
    end else if (cmd == CMD_SENSE) begin
      imm_ext = EXT_NONE;
    end else begin
      imm_ext = EXT_ABORT;
    end
  end

  // command sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg  <= S_IDLE;
      verify_reg <= 1'b0;
      last_reg   <= 1'b0;
      remain_reg <= 9'h000;
    end else begin
      case (state_reg)
        S_IDLE, S_XFER: begin
          if (cmd_wr && cmd_rw) begin
            state_reg  <= S_CHECK;
            verify_reg <= cmd[6];
            last_reg   <= 1'b0;
            remain_reg <= (count_reg == 8'h00) ? 9'(MAX_SECTORS) : {1'b0, count_reg};
          end else if (cmd_wr) begin
            state_reg <= S_IDLE;
          end else if (sector_drained) begin
            if (last_reg || remain_reg == 9'h001) begin
              state_reg <= S_IDLE;
            end else begin
              remain_reg <= remain_reg - 9'h001;
              state_reg  <= S_NEXT;
            end
          end
        end
        S_CHECK: begin
          state_reg <= chk_fail ? S_IDLE : S_WAIT;
        end
        S_WAIT: begin
          if (fetch_done) begin
            if (!verify_reg) begin
              state_reg <= S_XFER;
              last_reg  <= !fetch_ok;
            end else if (!fetch_ok || remain_reg == 9'h001) begin
              state_reg <= S_IDLE;
            end else begin
              remain_reg <= remain_reg - 9'h001;
              state_reg  <= S_NEXT;
            end
          end
        end
        S_NEXT: begin
          state_reg <= S_CHECK;
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // media request stays up for the whole fetch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      media_go      <= 1'b0;
      media_req     <= '0;
    end else if (state_reg == S_CHECK && !chk_fail) begin
      media_go         <= 1'b1;
      media_req.lba    <= lba;
      media_req.verify <= verify_reg;
    end else if (fetch_done) begin
      media_go <= 1'b0;
    end
  end

  // host-side word pointer into the sector buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_reg <= 8'h00;
    end else if (fetch_done) begin
      ptr_reg <= 8'h00;
    end else if (data_rd) begin
      ptr_reg <= ptr_reg + 8'h01;
    end
  end

  // task-file registers; host writes are ignored while busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg  <= RST_COUNT;
      sect_reg   <= RST_SECT;
      cyl_lo_reg <= RST_CYL;
      cyl_hi_reg <= RST_CYL;
      drvhd_reg  <= RST_DRVHD;
      feat_reg   <= 8'h00;
    end else if (state_reg == S_NEXT) begin
      count_reg <= remain_reg[7:0];
      if (drvhd_reg[DH_LBA]) begin
        {drvhd_reg[3:0], cyl_hi_reg, cyl_lo_reg, sect_reg} <=
          {drvhd_reg[3:0], cyl_hi_reg, cyl_lo_reg, sect_reg} + 28'h000_0001;
      end else if (32'(sect_reg) >= 32'(SPT)) begin
        sect_reg <= 8'h01;
        if (32'(drvhd_reg[3:0]) >= 32'(HEADS - 1)) begin
          drvhd_reg[3:0]         <= 4'h0;
          {cyl_hi_reg, cyl_lo_reg} <= {cyl_hi_reg, cyl_lo_reg} + 16'h0001;
        end else begin
          drvhd_reg[3:0] <= drvhd_reg[3:0] + 4'h1;
        end
      end else begin
        sect_reg <= sect_reg + 8'h01;
      end
    end else if (fetch_done && verify_reg && !fetch_ok) begin
      count_reg <= remain_reg[7:0];
    end else if (wr_acc && !busy) begin
      case (idx)
        3'(IDX_FEAT):   feat_reg   <= pwdata[7:0];
        3'(IDX_COUNT):  count_reg  <= pwdata[7:0];
        3'(IDX_SECT):   sect_reg   <= pwdata[7:0];
        3'(IDX_CYL_LO): cyl_lo_reg <= pwdata[7:0];
        3'(IDX_CYL_HI): cyl_hi_reg <= pwdata[7:0];
        3'(IDX_DRVHD):  drvhd_reg  <= pwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  // error reporting; the address registers are left untouched on failure
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_reg    <= RST_ERROR;
      ext_reg      <= EXT_NONE;
      err_flag_reg <= 1'b0;
    end else if (cmd_wr && cmd == CMD_SENSE) begin
      error_reg    <= ext_reg;
      ext_reg      <= EXT_NONE;
      err_flag_reg <= 1'b0;
    end else if (cmd_immediate) begin
      error_reg    <= (imm_ext == EXT_NONE) ? 8'h00 : ard_err_bits(imm_ext);
      ext_reg      <= imm_ext;
      err_flag_reg <= (imm_ext != EXT_NONE);
    end else if (cmd_wr) begin
      error_reg    <= 8'h00;
      ext_reg      <= EXT_NONE;
      err_flag_reg <= 1'b0;
    end else if (chk_fail) begin
      error_reg    <= ard_err_bits(chk_ext);
      ext_reg      <= chk_ext;
      err_flag_reg <= 1'b1;
    end else if (fetch_done && !fetch_ok) begin
      // media codes such as 35h, 36h, 09h, 10h, 3ah pass through unchanged
      error_reg    <= ard_err_bits(media_rsp.status);
      ext_reg      <= media_rsp.status;
      err_flag_reg <= 1'b1;
    end else if (fetch_done && media_rsp.status == EXT_CORR) begin
      ext_reg <= EXT_CORR;
    end
  end

  // interrupt line: set on completion or data ready, cleared by status read
  // or a new command; a set in the clearing cycle wins
  logic irq_set;
  logic irq_clr;

  assign irq_set = cmd_immediate || chk_fail ||
                   (fetch_done && !verify_reg) ||
                   (fetch_done && verify_reg && (!fetch_ok || remain_reg == 9'h001));
  assign irq_clr = (rd_acc && idx == 3'(IDX_CMD)) || cmd_wr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      intrq_reg <= 1'b0;
    end else if (irq_set) begin
      intrq_reg <= 1'b1;
    end else if (irq_clr) begin
      intrq_reg <= 1'b0;
    end
  end
endmodule

// file: inc/ard_pkg.sv
// constants, types and helpers shared by the sector read/verify command engine
// assumes a 32-bit apb master and a flash media engine that fills the sector buffer
package ard_pkg;

  // register indexes; byte address is four times the index
  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned IDX_DATA   = 0;
  localparam int unsigned IDX_FEAT   = 1;   // write: feature_select, read: error
  localparam int unsigned IDX_COUNT  = 2;   // transfer_length
  localparam int unsigned IDX_SECT   = 3;   // start_sector_low
  localparam int unsigned IDX_CYL_LO = 4;   // track_low_byte
  localparam int unsigned IDX_CYL_HI = 5;   // track_high_byte
  localparam int unsigned IDX_DRVHD  = 6;   // drive_head_select
  localparam int unsigned IDX_CMD    = 7;   // write: command_code, read: status

  // command codes
  localparam logic [7:0] CMD_READ_A   = 8'h20;
  localparam logic [7:0] CMD_READ_B   = 8'h21;
  localparam logic [7:0] CMD_VERIFY_A = 8'h40;
  localparam logic [7:0] CMD_VERIFY_B = 8'h41;
  localparam logic [7:0] CMD_SENSE    = 8'h03;
  localparam logic [3:0] CMD_RECAL_HI = 4'h1;
  localparam logic [3:0] CMD_SEEK_HI  = 4'h7;

  // extended error codes
  localparam logic [7:0] EXT_NONE      = 8'h00;
  localparam logic [7:0] EXT_TEST_OK   = 8'h01;
  localparam logic [7:0] EXT_WR_FAIL   = 8'h03;
  localparam logic [7:0] EXT_TEST_FAIL = 8'h05;
  localparam logic [7:0] EXT_MISC      = 8'h09;
  localparam logic [7:0] EXT_IDNF      = 8'h10;
  localparam logic [7:0] EXT_IDNF_B    = 8'h14;
  localparam logic [7:0] EXT_UNCORR    = 8'h11;
  localparam logic [7:0] EXT_CORR      = 8'h18;
  localparam logic [7:0] EXT_ABORT     = 8'h1f;
  localparam logic [7:0] EXT_BAD_ADDR  = 8'h21;
  localparam logic [7:0] EXT_OVERFLOW  = 8'h2f;
  localparam logic [7:0] EXT_VOLT_SUP  = 8'h35;
  localparam logic [7:0] EXT_VOLT_GEN  = 8'h36;
  localparam logic [7:0] EXT_SPARE     = 8'h3a;

  // status, error and drive/head bit positions
  localparam int unsigned ST_BSY   = 7;
  localparam int unsigned ST_RDY   = 6;
  localparam int unsigned ST_DSC   = 4;
  localparam int unsigned ST_DRQ   = 3;
  localparam int unsigned ST_ERR   = 0;
  localparam int unsigned ER_UNC   = 6;
  localparam int unsigned ER_IDNF  = 4;
  localparam int unsigned ER_ABRT  = 2;
  localparam int unsigned DH_LBA   = 6;
  localparam int unsigned DH_DRV   = 4;

  // reset values
  localparam logic [7:0] RST_COUNT = 8'h01;
  localparam logic [7:0] RST_SECT  = 8'h01;
  localparam logic [7:0] RST_CYL   = 8'h00;
  localparam logic [7:0] RST_DRVHD = 8'ha0;
  localparam logic [7:0] RST_ERROR = 8'h00;

  localparam int unsigned SECTOR_WORDS = 256;
  localparam int unsigned MAX_SECTORS  = 256;

  typedef struct packed {
    logic [27:0] lba;
    logic        verify;
  } ard_media_req_t;

  typedef struct packed {
    logic [7:0] status;   // extended code of the sector just fetched
    logic       done;
  } ard_media_rsp_t;

  // error register bits that go with an extended code
  function automatic logic [7:0] ard_err_bits(input logic [7:0] ext);
    logic [7:0] b;
    b = 8'h00;
    case (ext)
      EXT_UNCORR:                          b[ER_UNC]  = 1'b1;
      EXT_BAD_ADDR, EXT_OVERFLOW, EXT_IDNF,
      EXT_IDNF_B:                          b[ER_IDNF] = 1'b1;
      default:                             b[ER_ABRT] = 1'b1;
    endcase
    return b;
  endfunction

  // corrected data is still good data
  function automatic logic ard_ext_ok(input logic [7:0] ext);
    return (ext == EXT_NONE) || (ext == EXT_CORR);
  endfunction

endpackage

// file: hdl/ard_sbuf.sv
// one-sector word buffer: media side writes, host side reads through a register
// assumes the reader tolerates one cycle from address change to data
`timescale 1ns/1ps
module ard_sbuf #(
  parameter int unsigned WORDS = 256,
  parameter int unsigned DW    = 16
) (
  input  wire logic                     pclk,     // clock
  input  wire logic                     wr_en,    // write strobe
  input  wire logic [$clog2(WORDS)-1:0] wr_addr,  // write word address
  input  wire logic [DW-1:0]            wr_data,  // write word
  input  wire logic [$clog2(WORDS)-1:0] rd_addr,  // read word address
  output logic      [DW-1:0]            rd_data   // registered read word
);
  logic [DW-1:0] mem [WORDS];

  generate
    if (WORDS < 2) begin : g_chk
      $error("ard_sbuf needs at least two words");
    end
  endgenerate

  // no reset on the array so it maps onto block ram
  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// file: hdl/ard_addr.sv
// address former and range check for the task-file address
// assumes geometry parameters describe the whole card capacity
`timescale 1ns/1ps
module ard_addr
  import ard_pkg::*;
#(
  parameter int unsigned CYLS  = 1024,
  parameter int unsigned HEADS = 16,
  parameter int unsigned SPT   = 63,
  parameter int unsigned TOTAL = CYLS * HEADS * SPT
) (
  input  wire logic        lba_mode,  // logical block addressing selected
  input  wire logic [3:0]  head,      // head field, lba 27-24
  input  wire logic [15:0] cyl,       // cylinder, lba 23-8
  input  wire logic [7:0]  sect,      // sector number, lba 7-0
  output logic      [27:0] lba,       // linear block address
  output logic      [7:0]  ext        // range check result, 00h when in range
);
  logic [31:0] chs_lin;

  generate
    if (HEADS < 1 || HEADS > 16 || SPT < 1 || SPT > 255 || TOTAL > 32'h1000_0000) begin : g_chk
      $error("ard_addr geometry out of range");
    end
  endgenerate

  always_comb begin
    chs_lin = (32'(cyl) * 32'(HEADS) + 32'(head)) * 32'(SPT) + 32'(sect) - 32'h1;
    if (lba_mode) begin
      lba = {head, cyl, sect};
      ext = (32'(lba) >= 32'(TOTAL)) ? EXT_OVERFLOW : EXT_NONE;
    end else begin
      lba = chs_lin[27:0];
      if (sect == 8'h00 || 32'(sect) > 32'(SPT) || 32'(head) >= 32'(HEADS)) begin
        ext = EXT_BAD_ADDR;
      end else if (32'(cyl) >= 32'(CYLS)) begin
        ext = EXT_OVERFLOW;
      end else begin
        ext = EXT_NONE;
      end
    end
  end
endmodule

// file: bench/ard_cmd_exec_checker.sv
// port assertions for the command engine
// assumes it is bound onto ard_cmd_exec
`timescale 1ns/1ps
module ard_cmd_exec_checker
  import ard_pkg::*;
(
  input wire logic              pclk,      // clock
  input wire logic              presetn,   // reset
  input wire logic              psel,      // select
  input wire logic              penable,   // access
  input wire logic              pwrite,    // write
  input wire logic [ADDR_W-1:0] paddr,     // address
  input wire logic [31:0]       pwdata,    // write data
  input wire logic [31:0]       prdata,    // read data
  input wire logic              pready,    // ready
  input wire logic              intrq,     // interrupt
  input wire ard_media_req_t    media_req, // fetch fields
  input wire logic              media_go,  // fetch
  input wire ard_media_rsp_t    media_rsp  // completion
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire cw  = acc && pwrite && paddr == 12'h01c;
  sequence done_s;
    media_go && media_rsp.done;
  endsequence
  sequence next_s;
    (done_s and (media_rsp.status inside {8'h00, 8'h18})) ##3 media_go;
  endsequence
  ready_zero_a: assert property (acc |-> pready) else $error("pready low");
  rdata_idle_a: assert property (!(acc && !pwrite) |-> prdata == 32'h0)
    else $error("prdata not zero");
  go_hold_a: assert property (
    media_go && !media_rsp.done |=> media_go && $stable(media_req))
    else $error("fetch dropped early");
  go_drop_a: assert property (done_s |=> !media_go [*2])
    else $error("fetch not released");
  lba_step_a: assert property (
    next_s |-> media_req.lba == $past(media_req.lba, 3) + 28'h1)
    else $error("lba not consecutive");
  irq_cause_a: assert property ($rose(intrq) |->
    $past(media_rsp.done) || $past(cw) || $past(cw, 2) || $past(cw, 3)) else $error("stray irq");
  irq_clear_a: assert property ($fell(intrq) |-> $past(acc && paddr == 12'h01c))
    else $error("irq cleared without access");
  no_fetch_a: assert property (cw && !media_go && pwdata[7:4] inside {4'h1, 4'h7}
    |=> !media_go [*3]) else $error("immediate command fetched");
endmodule

// file: bench/ard_media_model.sv
// media engine model: fills the sector buffer, then pulses done
// assumes media_go is held until done; lag sets how slowly it answers
`timescale 1ns/1ps
module ard_media_model
  import ard_pkg::*;
(
  input  wire logic           pclk,        // clock
  input  wire logic           media_go,    // fetch
  input  wire ard_media_req_t media_req,   // fetch fields
  input  wire logic [27:0]    bad_lba,     // failing sector
  input  wire logic [7:0]     bad_code,    // its code
  input  wire logic [4:0]     lag,         // delay before fill
  output ard_media_rsp_t      media_rsp,   // completion
  output logic                media_wr,    // buffer write
  output logic [7:0]          media_waddr, // word address
  output logic [15:0]         media_wdata  // word
);
  initial begin
    media_rsp = '0;
    media_wr = 1'b0;
    media_waddr = 8'h00;
    media_wdata = 16'h0000;
    forever begin
      @(posedge pclk);
      if (media_go === 1'b1) begin
        repeat (lag) @(posedge pclk);
        for (int i = 0; i < 256; i++) begin
          media_wr <= 1'b1;
          media_waddr <= 8'(i);
          media_wdata <= {media_req.lba[7:0] ^ media_req.lba[15:8], 8'(i)};
          @(posedge pclk);
        end
        media_wr <= 1'b0;
        media_wdata <= ~media_wdata;
        media_rsp <= {(media_req.lba == bad_lba) ? bad_code : EXT_NONE, 1'b1};
        @(posedge pclk);
        media_rsp <= '0;
        @(posedge pclk);
      end
    end
  end
endmodule

// file: bench/ard_cmd_exec_tb_top.sv
// bench top: apb host tasks, media model and scenario sequence
// assumes default geometry and drive 0
`timescale 1ns/1ps
module ard_cmd_exec_tb_top
  import ard_pkg::*;
();
  logic           pclk, presetn, psel, penable, pwrite, se, iq_d;
  logic [11:0]    paddr;
  logic [31:0]    pwdata, prdata, rd;
  logic           pready, pslverr, intrq, media_go, media_wr;
  ard_media_req_t media_req;
  ard_media_rsp_t media_rsp;
  logic [7:0]     media_waddr, bad_code, st;
  logic [15:0]    media_wdata;
  logic [27:0]    bad_lba, a;
  logic [4:0]     lag;
  int             num_errors, check_count, irq_n, n0;
  logic [7:0] codes [9] = '{8'h11, 8'h18, 8'h09, 8'h35, 8'h36, 8'h10, 8'h14, 8'h03, 8'h3a};
  logic [7:0] rst_v [8] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'ha0, 8'h50};
  ard_cmd_exec ard_cmd_exec_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .intrq(intrq), .media_req(media_req),
    .media_go(media_go), .media_rsp(media_rsp), .media_wr(media_wr),
    .media_waddr(media_waddr), .media_wdata(media_wdata));
  ard_media_model ard_media_model_inst (.pclk(pclk), .media_go(media_go),
    .media_req(media_req), .bad_lba(bad_lba), .bad_code(bad_code), .lag(lag),
    .media_rsp(media_rsp), .media_wr(media_wr), .media_waddr(media_waddr),
    .media_wdata(media_wdata));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    iq_d <= intrq;
    if (intrq === 1'b1 && iq_d === 1'b0)
      irq_n <= irq_n + 1;
  end
  task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic timeout();
    num_errors++;
    give_verdict();
  endtask
  task automatic apb(input logic w, input logic [3:0] i, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {6'h00, i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (int n = 0; n <= 8; n++) begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
      if (n == 8)
        timeout();
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdck(input logic [3:0] i, input logic [7:0] e);
    apb(1'b0, i, 8'h00);
    ck($sformatf("reg%0d", i), {24'h0, e}, rd);
  endtask
  // wait for the interrupt, then read status, which also clears it
  task automatic irq_st();
    for (int n = 0; n <= 40000; n++) begin
      @(posedge pclk);
      if (intrq === 1'b1)
        break;
      if (n == 40000)
        timeout();
    end
    apb(1'b0, 4'd7, 8'h00);
    st = rd[7:0];
  endtask
  task automatic issue(input logic [7:0] c, input logic [27:0] l, input logic [7:0] n);
    apb(1'b1, 4'd2, n);
    apb(1'b1, 4'd3, l[7:0]);
    apb(1'b1, 4'd4, l[15:8]);
    apb(1'b1, 4'd5, l[23:16]);
    apb(1'b1, 4'd6, {4'he, l[27:24]});
    apb(1'b1, 4'd7, c);
    irq_st();
  endtask
  task automatic sense(input logic [7:0] e);
    apb(1'b1, 4'd7, CMD_SENSE);
    irq_st();
    rdck(4'd1, e);
  endtask
  task automatic drain(input logic [27:0] l);
    for (int i = 0; i < 256; i++) begin
      apb(1'b0, 4'd0, 8'h00);
      ck("data", {16'h0, l[7:0] ^ l[15:8], 8'(i)}, rd);
    end
  endtask
  function automatic logic [7:0] ebits(input logic [7:0] c);
    if (c == 8'h11)
      return 8'h40;
    if (c == 8'h10 || c == 8'h14 || c == 8'h21 || c == 8'h2f)
      return 8'h10;
    return 8'h04;
  endfunction
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    bad_lba = '1;
    bad_code = EXT_UNCORR;
    lag = 5'd0;
    void'($urandom(32'hbb7c));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 1; i < 8; i++)
      rdck(4'(i), rst_v[i]);
    apb(1'b0, 4'd8, 8'h00);
    ck("slverr", 32'h1, {31'h0, se});
    for (int k = 0; k < 2; k++) begin
      a = 28'($urandom % 32'h0f0000);
      lag <= 5'($urandom % 21);
      issue(k ? CMD_READ_B : CMD_READ_A, a, 8'h02);
      for (int s = 0; s < 2; s++) begin
        if (s > 0)
          irq_st();
        ck("rd status", 8'h58, st);
        drain(28'(a + s));
      end
      rdck(4'd7, 8'h50);
      n0 = irq_n;
      bad_lba <= a + 28'd2;
      issue(k ? CMD_VERIFY_B : CMD_VERIFY_A, a, 8'h04);
      ck("vf status", 8'h51, st);
      ck("vf irqs", 1, irq_n - n0);
      rdck(4'd2, 8'h02);
      rdck(4'd3, 8'(a + 2));
      rdck(4'd1, 8'h40);
      sense(EXT_UNCORR);
    end
    a = 28'h0000100;
    bad_lba <= a + 28'd100;
    issue(CMD_VERIFY_A, a, 8'h00);
    rdck(4'd2, 8'h9c);
    foreach (codes[j]) begin
      a = 28'($urandom % 32'h0f0000);
      bad_lba <= a;
      bad_code <= codes[j];
      issue(CMD_READ_A, a, 8'h01);
      ck("rf status", codes[j] == EXT_CORR ? 8'h58 : 8'h59, st);
      if (codes[j] != EXT_CORR)
        rdck(4'd1, ebits(codes[j]));
      drain(a);
      sense(codes[j]);
    end
    issue(CMD_RECAL_HI << 4 | 8'($urandom % 16), a, 8'h01);
    ck("recal", 8'h50, st);
    issue(8'h7f, 28'hfffffff, 8'h01);
    ck("seek bad", 8'h51, st);
    sense(EXT_OVERFLOW);
    sense(EXT_NONE);
    issue(8'h70, a, 8'h01);
    ck("seek ok", 8'h50, st);
    issue(8'hc8, a, 8'h01);
    ck("abort", 8'h51, st);
    rdck(4'd1, 8'h04);
    sense(EXT_ABORT);
    apb(1'b1, 4'd3, 8'h00);
    apb(1'b1, 4'd6, 8'ha0);
    apb(1'b1, 4'd7, 8'h70);
    irq_st();
    sense(EXT_BAD_ADDR);
    apb(1'b1, 4'd6, 8'hb0);
    apb(1'b1, 4'd7, 8'hc8);
    rdck(4'd7, 8'h50);
    give_verdict();
  end
endmodule
bind ard_cmd_exec ard_cmd_exec_checker ard_cmd_exec_checker_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .intrq(intrq),
  .media_req(media_req), .media_go(media_go), .media_rsp(media_rsp));
